// ---- src/asr_defs.vh ----
// constants for the async sram host controller
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH
`define ASR_ADDR_W            14
`define ASR_DATA_W            4
`define ASR_CLK_NS            10
`define ASR_WRITE_PERIOD_MIN  30
`define ASR_READ_PERIOD_MIN   30
`define ASR_SELECT_BEFORE_END 25
`define ASR_ADDR_BEFORE_END   25
`define ASR_DATA_BEFORE_END   15
`define ASR_DATA_AFTER_END    5
`define ASR_ADDR_TO_DATA      30
`define ASR_SELECT_TO_DATA    30
`define ASR_CYC(ns)           (((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_WR_PULSE_CYC      `ASR_CYC(`ASR_SELECT_BEFORE_END)
`define ASR_WR_HOLD_CYC       `ASR_CYC(`ASR_DATA_AFTER_END)
`define ASR_RD_WAIT_CYC       (`ASR_CYC(`ASR_ADDR_TO_DATA) + 1)
`define ASR_CNT_W             3
`endif

// ---- src/asr_sync.v ----
// two-stage synchroniser for the sram data pins
`timescale 1ns/100ps
module asr_sync (
   input  wire       i_clk_sys,
   input  wire       i_rst_n,
   input  wire [3:0] i_async,
   output wire [3:0] o_sync
);
   reg [3:0] meta_reg;
   reg [3:0] sync_reg;
   always @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         meta_reg <= 4'h0;
         sync_reg <= 4'h0;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end
   assign o_sync = sync_reg;
endmodule // asr_sync

// ---- src/asr_ctrl.v ----
// host controller driving a 16k x 4 asynchronous sram
// Functional notes
// - 16384 words of 4 bits, no clock
// - write only in select/strobe overlap, 25 ns
// - select and address 25 ns before end
// - data 15 ns before, 5 ns after end
// - write cycles at least 30 ns apart
// - read cycles at least 30 ns apart
// - never fight device driving data pins
`timescale 1ns/100ps
`include "asr_defs.vh"
module asr_ctrl (
   input  wire                     i_clk_sys,
   input  wire                     i_rst_n,
   input  wire                     i_req_valid,
   input  wire                     i_req_write,
   input  wire [`ASR_ADDR_W-1:0]   i_req_addr,
   input  wire [`ASR_DATA_W-1:0]   i_req_wdata,
   output wire                     o_req_ready,
   output reg                      o_rsp_valid,
   output reg  [`ASR_DATA_W-1:0]   o_rsp_rdata,
   output reg  [`ASR_ADDR_W-1:0]   o_mem_addr,
   output reg                      o_mem_select_n,
   output reg                      o_mem_write_strobe_n,
   input  wire [`ASR_DATA_W-1:0]   i_mem_data,
   output reg  [`ASR_DATA_W-1:0]   o_mem_data,
   output reg                      o_mem_data_oe_n
);
   // ************************************
   // states
   // ************************************
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_WSET  = 3'h1;
   localparam [2:0] ST_WPUL  = 3'h2;
   localparam [2:0] ST_WHOLD = 3'h3;
   localparam [2:0] ST_RWAIT = 3'h4;
   localparam [2:0] ST_RDONE = 3'h5;
   // cycle counts worked out as integers, then cut to the counter width
   localparam integer          WR_PULSE_I = `ASR_WR_PULSE_CYC;
   localparam integer          WR_HOLD_I  = `ASR_WR_HOLD_CYC;
   localparam integer          RD_WAIT_I  = `ASR_RD_WAIT_CYC;
   localparam [`ASR_CNT_W-1:0] WR_PULSE   = WR_PULSE_I[`ASR_CNT_W-1:0];
   localparam [`ASR_CNT_W-1:0] WR_HOLD    = WR_HOLD_I[`ASR_CNT_W-1:0];
   localparam [`ASR_CNT_W-1:0] RD_WAIT    = RD_WAIT_I[`ASR_CNT_W-1:0];

   reg [2:0]             state_reg;
   reg [`ASR_CNT_W-1:0]  cnt_reg;
   wire [`ASR_DATA_W-1:0] data_sync;

   // ************************************
   // data pin synchroniser
   // ************************************
   asr_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_async   (i_mem_data),
      .o_sync    (data_sync)
   );

   assign o_req_ready = (state_reg == ST_IDLE);

   // ************************************
   // access sequencer
   // ************************************
   always @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         state_reg            <= ST_IDLE;
         cnt_reg              <= {`ASR_CNT_W{1'b0}};
         o_rsp_valid          <= 1'b0;
         o_rsp_rdata          <= {`ASR_DATA_W{1'b0}};
         o_mem_addr           <= {`ASR_ADDR_W{1'b0}};
         o_mem_select_n       <= 1'b1;
         o_mem_write_strobe_n <= 1'b1;
         o_mem_data           <= {`ASR_DATA_W{1'b0}};
         o_mem_data_oe_n      <= 1'b1;
      end else begin
         o_rsp_valid <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (i_req_valid) begin
                  o_mem_addr     <= i_req_addr;
                  o_mem_select_n <= 1'b0;
                  if (i_req_write) begin
                     // strobe low before driving data keeps device floating
                     o_mem_write_strobe_n <= 1'b0;
                     o_mem_data           <= i_req_wdata;
                     state_reg            <= ST_WSET;
                  end else begin
                     cnt_reg   <= RD_WAIT;
                     state_reg <= ST_RWAIT;
                  end
               end
            end
            ST_WSET: begin
               o_mem_data_oe_n <= 1'b0;
               cnt_reg         <= WR_PULSE;
               state_reg       <= ST_WPUL;
            end
            ST_WPUL: begin
               if (cnt_reg == 3'h1) begin
                  o_mem_write_strobe_n <= 1'b1;
                  o_mem_select_n       <= 1'b1;
                  cnt_reg              <= WR_HOLD;
                  state_reg            <= ST_WHOLD;
               end else begin
                  cnt_reg <= cnt_reg - 3'h1;
               end
            end
            ST_WHOLD: begin
               if (cnt_reg == 3'h1) begin
                  o_mem_data_oe_n <= 1'b1;
                  o_rsp_valid     <= 1'b1;
                  state_reg       <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 3'h1;
               end
            end
            ST_RWAIT: begin
               if (cnt_reg == 3'h1) begin
                  state_reg <= ST_RDONE;
               end else begin
                  cnt_reg <= cnt_reg - 3'h1;
               end
            end
            ST_RDONE: begin
               o_rsp_rdata    <= data_sync;
               o_rsp_valid    <= 1'b1;
               o_mem_select_n <= 1'b1;
               state_reg      <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // asr_ctrl

// ---- test/asr_ctrl_monitor.sv ----
// pin checks for asr_ctrl
`timescale 1ns/100ps
module asr_ctrl_monitor (
   input logic i_clk_sys, i_rst_n, o_mem_select_n, o_mem_write_strobe_n, o_mem_data_oe_n,
   input logic [13:0] o_mem_addr,
   input logic [3:0] o_mem_data
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   chk_strobe_sel: assert property (!o_mem_write_strobe_n |-> !o_mem_select_n) else $error("bad strobe");
   chk_pulse_len: assert property ($fell(o_mem_write_strobe_n) |-> (!o_mem_write_strobe_n)[*3]) else $error("short");
   chk_data_setup: assert property ($rose(o_mem_write_strobe_n) |-> !$past(o_mem_data_oe_n, 2)) else $error("setup");
   chk_data_hold: assert property ($rose(o_mem_write_strobe_n) |-> !o_mem_data_oe_n && $stable(o_mem_data)) else $error("hold");
   chk_addr_write: assert property (!o_mem_write_strobe_n && !$past(o_mem_write_strobe_n) |-> $stable(o_mem_addr)) else $error("addr");
   chk_no_fight: assert property (!o_mem_data_oe_n |-> o_mem_select_n || !o_mem_write_strobe_n) else $error("fight");
   chk_write_gap: assert property ($fell(o_mem_write_strobe_n) |=> (!$fell(o_mem_write_strobe_n))[*2]) else $error("wgap");
   chk_read_addr: assert property ($fell(o_mem_select_n) && o_mem_write_strobe_n |=> $stable(o_mem_addr)[*3]) else $error("rd");
endmodule // asr_ctrl_monitor

// ---- test/asr_sram_model.sv ----
// behavioural 16k x 4 async sram at the far side
`timescale 1ns/100ps
module asr_sram_model (
   input logic [13:0] i_addr,
   input logic i_select_n, i_write_strobe_n,
   input logic [3:0] i_data,
   output logic [3:0] o_data,
   output logic o_drive
);
   logic [3:0] mem [0:16383];
   always @* if (!i_select_n && !i_write_strobe_n) mem[i_addr] = i_data;
   assign o_drive = !i_select_n && i_write_strobe_n;
   assign #20 o_data = mem[i_addr];
endmodule // asr_sram_model

// ---- test/tb_asr_ctrl.sv ----
// self-checking bench for asr_ctrl
`timescale 1ns/100ps
module tb_asr_ctrl;
   logic i_clk_sys = 0, i_rst_n = 0, i_req_valid = 0, i_req_write = 0, o_req_ready, o_rsp_valid, drv;
   logic o_mem_select_n, o_mem_write_strobe_n, o_mem_data_oe_n;
   logic [13:0] i_req_addr = 0, o_mem_addr;
   logic [3:0] i_req_wdata = 0, o_rsp_rdata, o_mem_data, i_mem_data, dd;
   logic [4:0] q[$];
   logic [13:0] aq[$];
   logic [3:0] m[logic [13:0]];
   logic [31:0] s = 32'hAAA7;
   int mismatches = 0, check_count = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   // pins released by both host and sram show the inverse of the last host value
   assign i_mem_data = !o_mem_data_oe_n ? o_mem_data : drv ? dd : ~o_mem_data;
   asr_ctrl dut (.*);
   asr_sram_model u_ram (.i_addr(o_mem_addr), .i_select_n(o_mem_select_n), .i_write_strobe_n(o_mem_write_strobe_n),
      .i_data(i_mem_data), .o_data(dd), .o_drive(drv));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic req(input logic w, input logic [13:0] a, input logic [3:0] d);
      i_req_valid = 1'b1;
      i_req_write = w;
      i_req_addr = a;
      i_req_wdata = d;
      q.push_back(w ? 5'h00 : {1'b1, m[a]});
      if (w) m[a] = d;
      while (o_req_ready !== 1'b1) @(posedge i_clk_sys) #1;
      @(posedge i_clk_sys) #1;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge i_clk_sys) if (o_rsp_valid === 1'b1) begin
      check_count++;
      if (q.size() == 0 || (q[0][4] && o_rsp_rdata !== q[0][3:0])) begin
         mismatches++;
         $display("CHECK FAILED %0t response", $time);
      end
      if (q.size() != 0) void'(q.pop_front());
   end
   initial begin
      repeat (10) @(posedge i_clk_sys);
      #1 i_rst_n = 1'b1;
      aq = '{14'h0000, 14'h3FFF};
      repeat (8) begin
         s = xs(s);
         aq.push_back(s[13:0]);
      end
      foreach (aq[i]) begin
         s = xs(s);
         req(1'b1, aq[i], s[3:0]);
         if (s[4]) req(1'b0, aq[i], s[7:4]);
      end
      foreach (aq[i]) req(1'b0, aq[i], s[7:4]);
      i_req_valid = 1'b0;
      repeat (10) @(posedge i_clk_sys);
      if (q.size() != 0) mismatches++;
      complete_run();
   end
   initial begin
      #100000;
      mismatches++;
      complete_run();
   end
endmodule // tb_asr_ctrl
bind asr_ctrl asr_ctrl_monitor u_mon (.*);
